// ==== design/nmls_core.sv ====
// Purpose: executes the load/store subset of the nibble core move instructions
// Assumes: instruction bytes and ROM data come from logic on clk_i; ROM read has one cycle latency
// Notes: one instruction cycle is one clk_i period after acceptance
// Behaviour
// - 0x0C loads accumulator from pointer-addressed RAM
// - 0x3C loads accumulator from direct address
// - 0x28 loads low/high pointers from aligned pair
// - 0x4k loads immediate into accumulator
// - 0xCk loads immediate into high pointer
// - 0x33 loads ROM low nibble via table pointer
// - 0x32 loads ROM high nibble, bumps pointer
// - 0x1A stores, increments low pointer, status=0 only when the low pointer wraps from 0xF
// - 0x3F stores accumulator at direct address
`timescale 1ns/1ps
module nmls_core #(
	parameter int AW = nmls_pkg::RAM_AW,
	parameter int TW = nmls_pkg::TP_W
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic instr_valid_i,
	input wire logic [7:0] instr_op_i,
	input wire logic [7:0] instr_arg_i,
	input wire logic tp_load_i,
	input wire logic [TW-1:0] tp_value_i,
	input wire logic carry_load_i,
	input wire logic carry_value_i,
	input wire logic [7:0] rom_data_i,
	output logic [TW-1:0] rom_addr_o,
	output logic busy_o,
	output logic done_o,
	output logic illegal_o,
	output logic [3:0] acc_o,
	output logic [3:0] high_pointer_reg_o,
	output logic [3:0] low_pointer_reg_o,
	output nmls_pkg::nmls_flags_t flags_o
);
	nmls_pkg::nmls_state_t state;
	nmls_pkg::nmls_state_t next_state;
	nmls_pkg::nmls_kind_t kind;
	nmls_pkg::nmls_kind_t next_kind;
	logic [3:0] imm;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] next_addr;
	logic [AW-1:0] ram_addr;
	logic ram_we;
	logic [3:0] ram_rdata;
	logic accept;
	logic two_cycle;
	logic final_c;
	logic [3:0] next_acc;
	logic acc_wr;
	logic [3:0] next_low;
	logic low_wr;
	logic [3:0] next_high;
	logic high_wr;

	assign accept = instr_valid_i && (state == nmls_pkg::ST_IDLE);

	// opcode decode into one execution kind
	always_comb
	begin
		next_kind = nmls_pkg::K_NONE;
		case (instr_op_i)
			nmls_pkg::OPC_LD_A_IND: next_kind = nmls_pkg::K_LD_A_IND;
			nmls_pkg::OPC_LD_A_DIR: next_kind = nmls_pkg::K_LD_A_DIR;
			nmls_pkg::OPC_LD_PAIR: next_kind = nmls_pkg::K_LD_PAIR;
			nmls_pkg::OPC_TBL_LO: next_kind = nmls_pkg::K_TBL_LO;
			nmls_pkg::OPC_TBL_HI: next_kind = nmls_pkg::K_TBL_HI;
			nmls_pkg::OPC_ST_IND: next_kind = nmls_pkg::K_ST_IND;
			nmls_pkg::OPC_ST_INC: next_kind = nmls_pkg::K_ST_INC;
			nmls_pkg::OPC_ST_DIR: next_kind = nmls_pkg::K_ST_DIR;
			default:
			begin
				case (instr_op_i[nmls_pkg::OPC_HI_MSB:nmls_pkg::OPC_HI_LSB])
					nmls_pkg::GRP_LD_A_IMM: next_kind = nmls_pkg::K_LD_A_IMM;
					nmls_pkg::GRP_LD_H_IMM: next_kind = nmls_pkg::K_LD_H_IMM;
					nmls_pkg::GRP_LD_L_IMM: next_kind = nmls_pkg::K_LD_L_IMM;
					default: next_kind = nmls_pkg::K_NONE;
				endcase
			end
		endcase
	end

	// data address chosen at acceptance
	always_comb
	begin
		case (next_kind)
			nmls_pkg::K_LD_A_DIR, nmls_pkg::K_ST_DIR: next_addr = instr_arg_i[AW-1:0];
			nmls_pkg::K_LD_PAIR: next_addr = {instr_arg_i[AW-1:nmls_pkg::PAIR_KEEP_LSB], 2'b00};
			default: next_addr = {high_pointer_reg_o, low_pointer_reg_o};
		endcase
	end

	// ram address: new address on accept, held address later; second word of a pair in cycle 1 (ST_C1)
	always_comb
	begin
		if (accept)
		begin
			ram_addr = next_addr;
		end
		else if (state == nmls_pkg::ST_C1 && kind == nmls_pkg::K_LD_PAIR)
		begin
			ram_addr = {addr_q[AW-1:1], 1'b1};
		end
		else
		begin
			ram_addr = addr_q;
		end
	end

	// stores write in their first cycle
	assign ram_we = (state == nmls_pkg::ST_C1) && ((kind == nmls_pkg::K_ST_IND) || (kind == nmls_pkg::K_ST_INC)
		|| (kind == nmls_pkg::K_ST_DIR));

	assign two_cycle = (kind == nmls_pkg::K_LD_A_DIR) || (kind == nmls_pkg::K_LD_PAIR) || (kind == nmls_pkg::K_TBL_LO)
		|| (kind == nmls_pkg::K_TBL_HI) || (kind == nmls_pkg::K_ST_DIR);
	assign final_c = (state == nmls_pkg::ST_C2) || (state == nmls_pkg::ST_C1 && !two_cycle);

	nmls_ram #(
		.AW(AW),
		.DW(nmls_pkg::NIB_W)
	) u_ram (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.we_i(ram_we),
		.addr_i(ram_addr),
		.wdata_i(acc_o),
		.rdata_o(ram_rdata)
	);

	// sequencing state
	always_comb
	begin
		case (state)
			nmls_pkg::ST_IDLE: next_state = instr_valid_i ? nmls_pkg::ST_C1 : nmls_pkg::ST_IDLE;
			nmls_pkg::ST_C1: next_state = two_cycle ? nmls_pkg::ST_C2 : nmls_pkg::ST_IDLE;
			nmls_pkg::ST_C2: next_state = nmls_pkg::ST_IDLE;
			default: next_state = nmls_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state <= nmls_pkg::ST_IDLE;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			illegal_o <= 1'b0;
		end
		else if (ce_i)
		begin
			state <= next_state;
			busy_o <= (next_state != nmls_pkg::ST_IDLE);
			done_o <= final_c;
			illegal_o <= final_c && (kind == nmls_pkg::K_NONE);
		end
	end

	// instruction latch
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			kind <= nmls_pkg::K_NONE;
			imm <= nmls_pkg::NIB_RESET;
			addr_q <= nmls_pkg::ADDR_RESET;
		end
		else if (ce_i && accept)
		begin
			kind <= next_kind;
			imm <= instr_op_i[nmls_pkg::OPC_LO_MSB:nmls_pkg::OPC_LO_LSB];
			addr_q <= next_addr;
		end
	end

	// register results written at the final edge
	always_comb
	begin
		next_acc = acc_o;
		acc_wr = 1'b0;
		next_low = low_pointer_reg_o;
		low_wr = 1'b0;
		next_high = high_pointer_reg_o;
		high_wr = 1'b0;
		case (kind)
			nmls_pkg::K_LD_A_IND, nmls_pkg::K_LD_A_DIR:
			begin
				next_acc = ram_rdata;
				acc_wr = 1'b1;
			end
			nmls_pkg::K_LD_A_IMM:
			begin
				next_acc = imm;
				acc_wr = 1'b1;
			end
			nmls_pkg::K_TBL_LO:
			begin
				next_acc = rom_data_i[nmls_pkg::ROM_LO_MSB:nmls_pkg::ROM_LO_LSB];
				acc_wr = 1'b1;
			end
			nmls_pkg::K_TBL_HI:
			begin
				next_acc = rom_data_i[nmls_pkg::ROM_HI_MSB:nmls_pkg::ROM_HI_LSB];
				acc_wr = 1'b1;
			end
			nmls_pkg::K_LD_H_IMM:
			begin
				next_high = imm;
				high_wr = 1'b1;
			end
			nmls_pkg::K_LD_L_IMM:
			begin
				next_low = imm;
				low_wr = 1'b1;
			end
			nmls_pkg::K_ST_INC:
			begin
				next_low = low_pointer_reg_o + nmls_pkg::NIB_ONE;
				low_wr = 1'b1;
			end
			default:
			begin
				next_acc = acc_o;
			end
		endcase
	end

	// accumulator and pointer registers; pair load fills low then high
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			acc_o <= nmls_pkg::NIB_RESET;
			low_pointer_reg_o <= nmls_pkg::NIB_RESET;
			high_pointer_reg_o <= nmls_pkg::NIB_RESET;
		end
		else if (ce_i)
		begin
			if (kind == nmls_pkg::K_LD_PAIR && state == nmls_pkg::ST_C1)
				low_pointer_reg_o <= ram_rdata;
			else if (final_c && low_wr)
				low_pointer_reg_o <= next_low;
			if (kind == nmls_pkg::K_LD_PAIR && state == nmls_pkg::ST_C2)
				high_pointer_reg_o <= ram_rdata;
			else if (final_c && high_wr)
				high_pointer_reg_o <= next_high;
			if (final_c && acc_wr)
				acc_o <= next_acc;
		end
	end

	// flags: carry only from outside, zero on accumulator loads and on 0x1A (from the new low pointer), status per instruction
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			flags_o <= nmls_pkg::FLAGS_RESET;
		end
		else if (ce_i)
		begin
			if (carry_load_i)
				flags_o.carry <= carry_value_i;
			if (final_c && kind != nmls_pkg::K_NONE)
			begin
				if (kind == nmls_pkg::K_ST_INC)
				begin
					flags_o.zero <= (next_low == nmls_pkg::NIB_RESET);
					flags_o.status <= (low_pointer_reg_o != nmls_pkg::NIB_ALL);
				end
				else
				begin
					flags_o.status <= 1'b1;
					if (acc_wr)
						flags_o.zero <= (next_acc == nmls_pkg::NIB_RESET);
				end
			end
		end
	end

	// table pointer drives the ROM address directly
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rom_addr_o <= nmls_pkg::TP_RESET;
		end
		else if (ce_i)
		begin
			if (final_c && kind == nmls_pkg::K_TBL_HI)
				rom_addr_o <= rom_addr_o + nmls_pkg::TP_ONE;
			else if (tp_load_i && state == nmls_pkg::ST_IDLE && !instr_valid_i)
				rom_addr_o <= tp_value_i;
		end
	end
endmodule

// ==== design/nmls_ram.sv ====
// Purpose: nibble-wide data RAM with registered read data
// Assumes: one clock, write and read share one address
// Notes: read data reflect the addressed word one edge later
`timescale 1ns/1ps
module nmls_ram #(
	parameter int AW = 8,
	parameter int DW = 4
) (
	input wire logic clk_i,
	input wire logic ce_i,
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [DW-1:0] wdata_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// write port
	always_ff @(posedge clk_i)
	begin
		if (ce_i && we_i)
		begin
			mem[addr_i] <= wdata_i;
		end
	end

	// registered read port
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			rdata_o <= mem[addr_i];
		end
	end
endmodule

// ==== include/nmls_pkg.sv ====
// Purpose: shared constants and types for the nibble core load/store executor
// Assumes: 4-bit data path, 8-bit data address, 12-bit table pointer
// Notes: opcode values and field positions live here only
package nmls_pkg;
	localparam int NIB_W = 4;
	localparam int RAM_AW = 8;
	localparam int TP_W = 12;
	localparam int BYTE_W = 8;

	// full one-byte opcodes
	localparam logic [7:0] OPC_LD_A_IND = 8'h0C;
	localparam logic [7:0] OPC_LD_A_DIR = 8'h3C;
	localparam logic [7:0] OPC_LD_PAIR = 8'h28;
	localparam logic [7:0] OPC_TBL_LO = 8'h33;
	localparam logic [7:0] OPC_TBL_HI = 8'h32;
	localparam logic [7:0] OPC_ST_IND = 8'h0F;
	localparam logic [7:0] OPC_ST_INC = 8'h1A;
	localparam logic [7:0] OPC_ST_DIR = 8'h3F;

	// upper-nibble groups carrying an immediate in the lower nibble
	localparam logic [3:0] GRP_LD_A_IMM = 4'h4;
	localparam logic [3:0] GRP_LD_H_IMM = 4'hC;
	localparam logic [3:0] GRP_LD_L_IMM = 4'hE;

	// field positions
	localparam int OPC_HI_MSB = 7;
	localparam int OPC_HI_LSB = 4;
	localparam int OPC_LO_MSB = 3;
	localparam int OPC_LO_LSB = 0;
	localparam int PAIR_KEEP_LSB = 2;
	localparam int ROM_HI_MSB = 7;
	localparam int ROM_HI_LSB = 4;
	localparam int ROM_LO_MSB = 3;
	localparam int ROM_LO_LSB = 0;

	// reset values and increment/limit constants
	localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
	localparam logic [TP_W-1:0] TP_RESET = 12'h000;
	localparam logic [RAM_AW-1:0] ADDR_RESET = 8'h00;
	localparam logic [NIB_W-1:0] NIB_ONE = 4'h1;
	localparam logic [NIB_W-1:0] NIB_ALL = 4'hF;
	localparam logic [TP_W-1:0] TP_ONE = 12'h001;

	typedef struct packed {
		logic carry;
		logic zero;
		logic status;
	} nmls_flags_t;

	localparam nmls_flags_t FLAGS_RESET = '{carry: 1'b0, zero: 1'b0, status: 1'b1};

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_C1 = 3'b010,
		ST_C2 = 3'b100
	} nmls_state_t;

	typedef enum logic [11:0] {
		K_NONE = 12'b000000000001,
		K_LD_A_IND = 12'b000000000010,
		K_LD_A_DIR = 12'b000000000100,
		K_LD_PAIR = 12'b000000001000,
		K_LD_A_IMM = 12'b000000010000,
		K_LD_H_IMM = 12'b000000100000,
		K_LD_L_IMM = 12'b000001000000,
		K_TBL_LO = 12'b000010000000,
		K_TBL_HI = 12'b000100000000,
		K_ST_IND = 12'b001000000000,
		K_ST_INC = 12'b010000000000,
		K_ST_DIR = 12'b100000000000
	} nmls_kind_t;
endpackage

// ==== testbench/nmls_core_assertions.sv ====
// Purpose: port-level timing and result checks for the load/store executor
// Assumes: ce_i stays high while an instruction runs
// Notes: bound into every nmls_core
`timescale 1ns/1ps
module nmls_core_chk #(
	parameter int TW = 12
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic ce_i,
	input wire logic instr_valid_i,
	input wire logic [7:0] instr_op_i,
	input wire logic carry_load_i,
	input wire logic [7:0] rom_data_i,
	input wire logic [TW-1:0] rom_addr_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic [3:0] acc_o,
	input wire logic [3:0] high_pointer_reg_o,
	input wire logic [3:0] low_pointer_reg_o,
	input wire nmls_pkg::nmls_flags_t flags_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// accept condition and opcode group
	wire logic take = ce_i && instr_valid_i && !busy_o;
	wire logic [3:0] hi = instr_op_i[7:4];
	wire logic [3:0] lo = low_pointer_reg_o;
	imm_acc_a: assert property (take && hi == 4'h4 |=> ##1 acc_o == $past(instr_op_i[3:0], 2)
		&& flags_o.status && flags_o.zero == (acc_o == 4'h0)) else $error("immediate acc load wrong");
	imm_high_a: assert property (take && hi == 4'hC |=> ##1
		high_pointer_reg_o == $past(instr_op_i[3:0], 2) && $stable(flags_o.zero)) else $error("high load wrong");
	imm_low_a: assert property (take && hi == 4'hE |=> ##1
		low_pointer_reg_o == $past(instr_op_i[3:0], 2) && flags_o.status) else $error("low load wrong");
	st_inc_a: assert property (take && instr_op_i == 8'h1A |=> ##1 lo == $past(lo, 2) + 4'h1
		&& flags_o.status == ($past(lo, 2) != 4'hF) && flags_o.zero == (lo == 4'h0)) else $error("store inc wrong");
	tbl_lo_a: assert property (take && instr_op_i == 8'h33 |=> ##2
		acc_o == $past(rom_data_i[3:0]) && $stable(rom_addr_o)) else $error("table low read wrong");
	tbl_hi_a: assert property (take && instr_op_i == 8'h32 |=> ##2 acc_o == $past(rom_data_i[7:4])
		&& rom_addr_o == TW'($past(rom_addr_o, 3) + 1'b1)) else $error("table high read wrong");
	ind_time_a: assert property (take && instr_op_i == 8'h0C |=> busy_o && !done_o ##1
		done_o && !busy_o && flags_o.status) else $error("indirect load timing wrong");
	two_cyc_a: assert property (take && instr_op_i inside {8'h3C, 8'h28, 8'h33, 8'h32, 8'h3F} |=>
		busy_o [*2] ##1 done_o && !busy_o && flags_o.status) else $error("two-cycle timing wrong");
	carry_keep_a: assert property (!carry_load_i |=> $stable(flags_o.carry))
		else $error("carry changed");
	st_zero_a: assert property (take && instr_op_i == 8'h0F |=> ##1 $stable(flags_o.zero) && done_o)
		else $error("store changed zero");
	cover property (take && hi == 4'h4);
	cover property (take && instr_op_i == 8'h32);
	cover property (take && instr_op_i == 8'h1A && lo == 4'hF);
endmodule
bind nmls_core nmls_core_chk #(.TW(TW)) chk_i (.clk_i, .reset_i, .ce_i, .instr_valid_i, .instr_op_i,
	.carry_load_i, .rom_data_i, .rom_addr_o, .busy_o, .done_o, .acc_o, .high_pointer_reg_o,
	.low_pointer_reg_o, .flags_o);

// ==== testbench/nmls_rom_model.sv ====
// Purpose: program ROM data table seen through the table pointer
// Assumes: one cycle read latency
// Notes: byte content is a fixed pattern of the address
`timescale 1ns/1ps
module nmls_rom_model #(
	parameter int TW = 12
) (
	input wire logic clk_i,
	input wire logic [TW-1:0] addr_i,
	output logic [7:0] data_o
);
	// registered read of the pattern byte
	always_ff @(posedge clk_i)
		data_o <= 8'(addr_i * 7 + 3);
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: self-checking bench for the load/store executor
// Assumes: ce_i high except in the freeze case
// Notes: data RAM is filled first so every later load is defined
`timescale 1ns/1ps
module tb_top;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic ce_i = 1'b1;
	logic instr_valid_i = 1'b0;
	logic tp_load_i = 1'b0;
	logic carry_load_i = 1'b0;
	logic carry_value_i = 1'b0;
	logic [7:0] instr_op_i = 8'h00;
	logic [7:0] instr_arg_i = 8'h00;
	logic [11:0] tp_value_i = 12'h000;
	logic [7:0] rom_data_i;
	logic [11:0] rom_addr_o;
	logic busy_o, done_o, illegal_o;
	logic [3:0] acc_o, high_pointer_reg_o, low_pointer_reg_o;
	nmls_pkg::nmls_flags_t flags_o;
	int failures = 0, cmp_count = 0, cyc = 0;
	int m[256];
	int a = 0, h = 0, l = 0, tp = 0;
	logic c = 1'b0, z = 1'b0, s = 1'b1;
	logic [7:0] o;
	logic [7:0] ops[11] = '{8'h0C, 8'h3C, 8'h28, 8'h40, 8'hC0, 8'hE0, 8'h33, 8'h32, 8'h0F, 8'h1A, 8'h3F};
	// clock
	always #5 clk_i = ~clk_i;
	nmls_core dut (.clk_i, .reset_i, .ce_i, .instr_valid_i, .instr_op_i, .instr_arg_i, .tp_load_i, .tp_value_i,
		.carry_load_i, .carry_value_i, .rom_data_i, .rom_addr_o, .busy_o, .done_o, .illegal_o, .acc_o,
		.high_pointer_reg_o, .low_pointer_reg_o, .flags_o);
	nmls_rom_model rom (.clk_i, .addr_i(rom_addr_o), .data_o(rom_data_i));
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task wrap_up;
		$display("failures %0d checks %0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// table pointer and carry load together while idle
	task side(input int v, input logic cv);
		@(posedge clk_i);
		tp_load_i <= 1'b1;
		tp_value_i <= 12'(v);
		carry_load_i <= 1'b1;
		carry_value_i <= cv;
		@(posedge clk_i);
		tp_load_i <= 1'b0;
		carry_load_i <= 1'b0;
		tp = v;
		c = cv;
	endtask
	// one instruction, then model update and compare
	task run(input logic [7:0] o, input logic [7:0] x, input bit frz);
		int n;
		int ad;
		logic lg;
		@(posedge clk_i);
		ce_i <= !frz;
		instr_valid_i <= 1'b1;
		instr_op_i <= o;
		instr_arg_i <= x;
		if (frz)
		begin
			repeat (3) @(posedge clk_i);
			#1 chk("frozen", 8'(acc_o), 8'(a));
			@(posedge clk_i);
			ce_i <= 1'b1;
		end
		@(posedge clk_i);
		instr_valid_i <= 1'b0;
		for (n = 1; n < 5; n++)
		begin
			@(posedge clk_i);
			#1;
			if (done_o === 1'b1)
				break;
		end
		lg = o inside {8'h0C, 8'h3C, 8'h28, 8'h33, 8'h32, 8'h0F, 8'h1A, 8'h3F} || o[7:4] inside {4'h4, 4'hC, 4'hE};
		chk("cycles", 8'(n), (o inside {8'h3C, 8'h28, 8'h33, 8'h32, 8'h3F}) ? 8'h02 : 8'h01);
		chk("illegal", 8'(illegal_o), 8'(!lg));
		ad = h * 16 + l;
		case (1'b1)
			o[7:4] == 4'h4: a = o[3:0];
			o[7:4] == 4'hC: h = o[3:0];
			o[7:4] == 4'hE: l = o[3:0];
			o == 8'h0C: a = m[ad];
			o == 8'h3C: a = m[x];
			o == 8'h28:
			begin
				l = m[x & 8'hFC];
				h = m[(x & 8'hFC) + 1];
			end
			o == 8'h33: a = ((tp * 7 + 3) % 256) % 16;
			o == 8'h32:
			begin
				a = ((tp * 7 + 3) % 256) / 16;
				tp = (tp + 1) % 4096;
			end
			o inside {8'h0F, 8'h1A, 8'h3F}: m[o == 8'h3F ? x : ad] = a;
		endcase
		if (o inside {8'h0C, 8'h3C, 8'h33, 8'h32} || o[7:4] == 4'h4)
			z = (a == 0);
		if (o == 8'h1A)
		begin
			s = (l != 15);
			l = (l + 1) % 16;
			z = (l == 0);
		end
		else if (lg)
			s = 1'b1;
		chk("acc", 8'(acc_o), 8'(a));
		chk("high", 8'(high_pointer_reg_o), 8'(h));
		chk("low", 8'(low_pointer_reg_o), 8'(l));
		chk("flags", 8'(flags_o), 8'({c, z, s}));
		chk("tp", 8'(rom_addr_o), 8'(tp));
		chk("tp_hi", 8'(rom_addr_o[11:8]), 8'(tp / 256));
	endtask
	// main sequence
	initial
	begin
		void'($urandom(82));
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		#1 chk("flags", 8'(flags_o), 8'h01);
		for (int i = 0; i < 256; i++)
		begin
			run(8'h40 | 8'(i % 16), 8'h00, 1'b0);
			run(8'h3F, 8'(i), 1'b0);
		end
		run(8'h45, 8'h00, 1'b1);
		run(8'h01, 8'h00, 1'b0);
		run(8'hEF, 8'h00, 1'b0);
		run(8'h1A, 8'h00, 1'b0);
		for (int i = 0; i < 300; i++)
		begin
			o = ops[$urandom % 11];
			if (o[3:0] == 4'h0)
				o[3:0] = 4'($urandom);
			if ($urandom % 4 == 0)
				side($urandom % 4096, 1'($urandom));
			run(o, 8'($urandom), 1'b0);
		end
		wrap_up;
	end
	// hang guard
	always @(posedge clk_i)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			failures++;
			wrap_up;
		end
	end
endmodule
